//--- design/rbs_pkg.sv
// Functional notes
// - Five reset sources: power-on, pin, watchdog, wake, brownout
// - Boot option latched at reset end, cold-only
// - Pin reset works running or powered down
// - Malfunction timer expiry resets the device
// - RAM kept on wake, unreliable after power-on
// - Wake reset switches voltage regulator back on
// - Cold reset picks boot from TMS and select
// - TMS low loader, else select low debug
// - Boot options only with default pin assignment
// - User entry needs TMS, key, flash, count
// - Delay is (count minus one) times 5 ms
// - Idle count 01 jumps to user immediately
// - Counts 00 and 0D-FF stay in loader
// - Count valid only when inverted copy matches
// - Loader frame during delay blocks user entry
// - Valid count with TMS, key and flash met reaches user without activity
package rbs_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ         = 20_000_000;
    localparam int CLK_PERIOD_NS  = 50;
    localparam int HW_RST_MIN_NS  = 100;
    localparam int HW_RST_CYC     = (HW_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DELAY_UNIT_MS  = 5;
    localparam int DELAY_UNIT_CYC = CLK_HZ / 1000 * DELAY_UNIT_MS;
    localparam int RST_SEQ_CYC    = 8;
    localparam int TICK_W         = 17;
    localparam int SEQ_W          = 4;
    localparam int HW_W           = 2;

    // ----------------------------------------------------------------
    // Constants and offsets
    // ----------------------------------------------------------------
    localparam logic [7:0]  IDLE_MIN    = 8'h01;
    localparam logic [7:0]  IDLE_MAX    = 8'h0C;
    localparam logic [7:0]  KEY_OPEN    = 8'h00;
    localparam logic [15:0] PC_BOOT     = 16'h0000;
    localparam logic [7:0]  OFS_STATUS  = 8'h00;
    localparam logic [7:0]  OFS_NVPARAM = 8'h04;
    localparam logic [7:0]  OFS_CTRL    = 8'h08;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef logic [7:0]  rbs_addr_t;
    typedef logic [31:0] rbs_word_t;

    typedef enum logic [1:0] {
        RBS_MODE_NONE   = 2'b00,
        RBS_MODE_LOADER = 2'b01,
        RBS_MODE_DEBUG  = 2'b10,
        RBS_MODE_USER   = 2'b11
    } rbs_mode_e;

    typedef enum logic [1:0] {
        RBS_ST_RESET = 2'b00,
        RBS_ST_DELAY = 2'b01,
        RBS_ST_RUN   = 2'b10
    } rbs_state_e;

    typedef struct packed {
        logic brownout;
        logic wake;
        logic watchdog;
        logic hardware;
        logic power_on;
    } rbs_cause_s;

    typedef struct packed {
        logic [6:0] rsvd;
        logic       flash0_nonzero;
        logic [7:0] key;
        logic [7:0] idle_inv;
        logic [7:0] idle_count;
    } rbs_nv_s;

    typedef struct packed {
        logic [16:0] rsvd;
        logic [3:0]  delay_left;
        logic [1:0]  boot_opt;
        logic        regulator_on;
        logic        ram_valid;
        rbs_cause_s  cause;
        rbs_mode_e   mode;
    } rbs_status_s;

    typedef struct packed {
        logic [29:0] rsvd;
        logic        power_down;
        logic        ram_init_done;
    } rbs_ctrl_s;

    function automatic logic idle_valid(input rbs_nv_s nv);
        idle_valid = (nv.idle_inv == ~nv.idle_count) &&
                     (nv.idle_count >= IDLE_MIN) && (nv.idle_count <= IDLE_MAX);
    endfunction

endpackage

//--- design/rbs_tick.sv
`timescale 1ns/10ps
module rbs_tick #(
    parameter int TICK_CYC = rbs_pkg::DELAY_UNIT_CYC
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic run,
    output logic      tick
);
    logic [rbs_pkg::TICK_W-1:0] cnt;
    wire                        wrap = (cnt == rbs_pkg::TICK_W'(TICK_CYC - 1));

    always_ff @(posedge clk) begin
        if (rst || !run || wrap) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

    assign tick = run && wrap;
endmodule

//--- design/rbs_top.sv
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/10ps
module rbs_top #(
    parameter int DELAY_UNIT_CYC = rbs_pkg::DELAY_UNIT_CYC
) (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               por_req,
    input  wire logic               reset_pin_n,
    input  wire logic               malfunction_timer_expire,
    input  wire logic               wake_req,
    input  wire logic               brownout_req,
    input  wire logic               tms,
    input  wire logic               boot_select_pin,
    input  wire logic               default_pins,
    input  wire logic               loader_frame,
    input  wire rbs_pkg::rbs_addr_t bus_addr,
    input  wire rbs_pkg::rbs_word_t bus_wdata,
    input  wire logic               bus_wr,
    input  wire logic               bus_rd,
    output rbs_pkg::rbs_word_t      bus_rdata,
    output logic                    sys_reset,
    output rbs_pkg::rbs_mode_e      boot_mode,
    output logic [15:0]             pc_start,
    output logic                    osc_pll_bypass,
    output logic                    user_jump,
    output logic                    ram_valid,
    output logic                    regulator_on,
    output logic                    power_down
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    rbs_pkg::rbs_state_e   st;
    rbs_pkg::rbs_state_e   next_st;
    rbs_pkg::rbs_mode_e    next_mode;
    rbs_pkg::rbs_cause_s   cause;
    rbs_pkg::rbs_cause_s   new_cause;
    rbs_pkg::rbs_nv_s      nv;
    logic [rbs_pkg::SEQ_W-1:0] seq_cnt;
    logic [rbs_pkg::HW_W-1:0]  hw_cnt;
    logic [1:0]            boot_opt;
    logic [3:0]            left;
    logic [3:0]            next_left;
    logic                  next_jump;
    logic                  tick;

    // ----------------------------------------------------------------
    // Source decode
    // ----------------------------------------------------------------
    // pin must stay low the minimum time before it counts
    wire hw_hit  = !reset_pin_n && (hw_cnt == rbs_pkg::HW_W'(rbs_pkg::HW_RST_CYC - 1));
    // five sources, pin even in power-down, watchdog
    assign new_cause = '{brownout: brownout_req,
                         wake:     wake_req && power_down,
                         watchdog: malfunction_timer_expire,
                         hardware: hw_hit,
                         power_on: por_req};
    wire any_src = |new_cause;
    wire cold    = cause.power_on || cause.hardware;
    wire seq_end = (seq_cnt == rbs_pkg::SEQ_W'(rbs_pkg::RST_SEQ_CYC - 1));
    wire decide  = (st == rbs_pkg::RBS_ST_RESET) && seq_end && !any_src;
    // only a cold reset takes new pin levels
    wire latch_boot = decide && cold;
    // cold reset uses live pins, warm ones the latched option
    wire [1:0] opt  = cold ? {tms, boot_select_pin} : boot_opt;
    wire entry_ok = !opt[1] && (nv.key == rbs_pkg::KEY_OPEN) && nv.flash0_nonzero &&
                    rbs_pkg::idle_valid(nv);
    wire at_min   = (nv.idle_count == rbs_pkg::IDLE_MIN);
    wire last_tick = tick && (left == 4'h1);

    wire wr_nv   = bus_wr && (bus_addr == rbs_pkg::OFS_NVPARAM);
    wire wr_ctrl = bus_wr && (bus_addr == rbs_pkg::OFS_CTRL);
    rbs_pkg::rbs_ctrl_s ctrl_w;
    assign ctrl_w = bus_wdata;

    rbs_tick #(
        .TICK_CYC (DELAY_UNIT_CYC)
    ) u_tick (
        .clk  (clk),
        .rst  (rst),
        .run  (st == rbs_pkg::RBS_ST_DELAY),
        .tick (tick)
    );

    // ----------------------------------------------------------------
    // Boot decision
    // ----------------------------------------------------------------
    always_comb begin
        next_st   = st;
        next_mode = boot_mode;
        next_left = left;
        next_jump = 1'b0;
        case (st)
            rbs_pkg::RBS_ST_RESET: begin
                if (decide) begin
                    next_st = rbs_pkg::RBS_ST_RUN;
                    // nonstandard pin map ignores the straps
                    if (!default_pins) begin
                        next_mode = rbs_pkg::RBS_MODE_USER;
                    end else if (!opt[1]) begin
                        next_mode = rbs_pkg::RBS_MODE_LOADER;
                        if (entry_ok && at_min) begin
                            next_mode = rbs_pkg::RBS_MODE_USER;
                            next_jump = 1'b1;
                        end else if (entry_ok) begin
                            next_st   = rbs_pkg::RBS_ST_DELAY;
                            next_left = 4'(nv.idle_count - rbs_pkg::IDLE_MIN);
                        end
                    // TMS high, select low enters debug
                    end else if (!opt[0]) begin
                        next_mode = rbs_pkg::RBS_MODE_DEBUG;
                    end else begin
                        next_mode = rbs_pkg::RBS_MODE_USER;
                    end
                end
            end
            rbs_pkg::RBS_ST_DELAY: begin
                // frame keeps the loader in charge
                if (loader_frame) begin
                    next_st = rbs_pkg::RBS_ST_RUN;
                // quiet delay always ends in user mode
                end else if (last_tick) begin
                    next_st   = rbs_pkg::RBS_ST_RUN;
                    next_mode = rbs_pkg::RBS_MODE_USER;
                    next_jump = 1'b1;
                    next_left = 4'h0;
                end else if (tick) begin
                    next_left = left - 4'h1;
                end
            end
            rbs_pkg::RBS_ST_RUN: begin
                next_st = st;
            end
            default: begin
                next_st = rbs_pkg::RBS_ST_RESET;
            end
        endcase
        // Any source restarts the sequence, even mid-delay
        if (any_src) begin
            next_st   = rbs_pkg::RBS_ST_RESET;
            next_mode = rbs_pkg::RBS_MODE_NONE;
            next_jump = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st        <= rbs_pkg::RBS_ST_RESET;
            boot_mode <= rbs_pkg::RBS_MODE_NONE;
            left      <= 4'h0;
            user_jump <= 1'b0;
        end else begin
            st        <= next_st;
            boot_mode <= next_mode;
            left      <= next_left;
            user_jump <= next_jump;
        end
    end

    // ----------------------------------------------------------------
    // Reset sequence and causes
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            hw_cnt  <= '0;
            seq_cnt <= '0;
            cause   <= '{power_on: 1'b1, default: 1'b0};
        end else begin
            if (reset_pin_n) begin
                hw_cnt <= '0;
            end else if (!hw_hit) begin
                hw_cnt <= hw_cnt + 1'b1;
            end
            if (any_src || st != rbs_pkg::RBS_ST_RESET) begin
                seq_cnt <= '0;
            end else if (!seq_end) begin
                seq_cnt <= seq_cnt + 1'b1;
            end
            // causes accumulate while the sequence is open
            if (any_src) begin
                cause <= (st == rbs_pkg::RBS_ST_RESET) ? (cause | new_cause) : new_cause;
            end
        end
    end

    // option held until the next cold reset
    always_ff @(posedge clk) begin
        if (rst) begin
            boot_opt <= 2'h0;
        end else if (latch_boot) begin
            boot_opt <= {tms, boot_select_pin};
        end
    end

    // fixed start address, clocks not bypassed
    always_ff @(posedge clk) begin
        if (rst) begin
            pc_start       <= rbs_pkg::PC_BOOT;
            osc_pll_bypass <= 1'b0;
        end else begin
            pc_start       <= rbs_pkg::PC_BOOT;
            osc_pll_bypass <= 1'b0;
        end
    end

    assign sys_reset = (st == rbs_pkg::RBS_ST_RESET);

    // ----------------------------------------------------------------
    // Memory and regulator effects
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            ram_valid    <= 1'b0;
            regulator_on <= 1'b1;
            power_down   <= 1'b0;
        end else begin
            // power-on or brownout loss beats a same-cycle software mark
            if (new_cause.power_on || new_cause.brownout) begin
                ram_valid <= 1'b0;
            end else if (wr_ctrl && ctrl_w.ram_init_done) begin
                ram_valid <= 1'b1;
            end
            // any reset, wake included, restores the regulator
            if (any_src) begin
                regulator_on <= 1'b1;
                power_down   <= 1'b0;
            end else if (wr_ctrl) begin
                regulator_on <= !ctrl_w.power_down;
                power_down   <= ctrl_w.power_down;
            end
        end
    end

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    rbs_pkg::rbs_status_s status;
    assign status = '{rsvd: '0, delay_left: left, boot_opt: boot_opt,
                      regulator_on: regulator_on, ram_valid: ram_valid,
                      cause: cause, mode: boot_mode};

    always_ff @(posedge clk) begin
        if (rst) begin
            nv <= '0;
        end else if (wr_nv) begin
            nv <= '{rsvd: '0, flash0_nonzero: bus_wdata[24], key: bus_wdata[23:16],
                    idle_inv: bus_wdata[15:8], idle_count: bus_wdata[7:0]};
        end
    end

    // Unmapped reads return zero; strobes never stall
    always_ff @(posedge clk) begin
        if (rst || !bus_rd) begin
            bus_rdata <= '0;
        end else begin
            case (bus_addr)
                rbs_pkg::OFS_STATUS:  bus_rdata <= status;
                rbs_pkg::OFS_NVPARAM: bus_rdata <= nv;
                rbs_pkg::OFS_CTRL:    bus_rdata <= {30'h0, power_down, ram_valid};
                default:              bus_rdata <= '0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_hw_rst;
        !reset_pin_n ##1 !reset_pin_n |=> sys_reset && cause.hardware;
    endproperty
    a_hw_rst: assert property (p_hw_rst) else $error("pin reset not taken");

    property p_pd_pin;
        power_down && !reset_pin_n ##1 !reset_pin_n |=> sys_reset && !power_down;
    endproperty
    a_pd_pin: assert property (p_pd_pin) else $error("pin reset lost in power-down");

    property p_wdt;
        malfunction_timer_expire |=> sys_reset && boot_mode == rbs_pkg::RBS_MODE_NONE;
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog reset missed");

    property p_wake;
        power_down && wake_req |=> regulator_on && sys_reset && cause.wake;
    endproperty
    a_wake: assert property (p_wake) else $error("wake did not restore regulator");

    property p_ram_cold;
        por_req || brownout_req |=> !ram_valid;
    endproperty
    a_ram_cold: assert property (p_ram_cold) else $error("ram still valid after cold");

    property p_ram_keep;
        ram_valid && !por_req && !brownout_req |=> ram_valid;
    endproperty
    a_ram_keep: assert property (p_ram_keep) else $error("ram lost on warm reset");

    property p_boot_hold;
        $changed(boot_opt) |-> $past(latch_boot);
    endproperty
    a_boot_hold: assert property (p_boot_hold) else $error("boot option moved");

    property p_imm;
        decide && default_pins && entry_ok && at_min |=>
            boot_mode == rbs_pkg::RBS_MODE_USER && user_jump;
    endproperty
    a_imm: assert property (p_imm) else $error("count 01 not immediate");

    property p_invalid;
        decide && default_pins && !opt[1] && !rbs_pkg::idle_valid(nv) |=>
            boot_mode == rbs_pkg::RBS_MODE_LOADER && st == rbs_pkg::RBS_ST_RUN;
    endproperty
    a_invalid: assert property (p_invalid) else $error("invalid count left loader");

    property p_debug;
        decide && default_pins && opt[1] && !opt[0] |=>
            boot_mode == rbs_pkg::RBS_MODE_DEBUG && pc_start == rbs_pkg::PC_BOOT;
    endproperty
    a_debug: assert property (p_debug) else $error("debug boot wrong");

    property p_nodef;
        decide && !default_pins |=> boot_mode == rbs_pkg::RBS_MODE_USER;
    endproperty
    a_nodef: assert property (p_nodef) else $error("straps used with custom pins");

    property p_frame;
        st == rbs_pkg::RBS_ST_DELAY && loader_frame && !any_src |=>
            (st == rbs_pkg::RBS_ST_RUN && boot_mode == rbs_pkg::RBS_MODE_LOADER) [*2];
    endproperty
    a_frame: assert property (p_frame) else $error("frame did not cancel jump");

    property p_delay;
        st == rbs_pkg::RBS_ST_DELAY && !tick && !loader_frame && !any_src |=>
            $stable(left) && st == rbs_pkg::RBS_ST_DELAY;
    endproperty
    a_delay: assert property (p_delay) else $error("delay moved without tick");

    property p_expire;
        st == rbs_pkg::RBS_ST_DELAY && last_tick && !loader_frame && !any_src |=>
            user_jump && boot_mode == rbs_pkg::RBS_MODE_USER;
    endproperty
    a_expire: assert property (p_expire) else $error("delay end missed user");

    c_delay_user: cover property (st == rbs_pkg::RBS_ST_DELAY ##1 user_jump);
    c_frame:      cover property (st == rbs_pkg::RBS_ST_DELAY && loader_frame);
    c_debug:      cover property (boot_mode == rbs_pkg::RBS_MODE_DEBUG);
    c_wake:       cover property (power_down && wake_req);
endmodule

//--- tb/rbs_far_side.sv
`timescale 1ns/10ps
module rbs_far_side (
    input  wire logic clk,
    output logic      reset_pin_n,
    output logic      tms,
    output logic      boot_select_pin,
    output logic      loader_frame
);
    initial begin
        reset_pin_n = 1'b1;
        tms = 1'b0;
        boot_select_pin = 1'b0;
        loader_frame = 1'b0;
    end

    // pin low time
    // Whole cycles only; one cycle (50 ns) is below the minimum and must be ignored
    task automatic pin_reset(input int cyc);
        @(posedge clk);
        reset_pin_n <= 1'b0;
        repeat (cyc) @(posedge clk);
        reset_pin_n <= 1'b1;
    endtask

    // Straps settle before the reset that samples them
    task automatic set_straps(input logic t, input logic b);
        @(posedge clk);
        tms <= t;
        boot_select_pin <= b;
    endtask

    task automatic send_frame();
        @(posedge clk);
        loader_frame <= 1'b1;
        @(posedge clk);
        loader_frame <= 1'b0;
    endtask
endmodule

//--- tb/testbench.sv
`timescale 1ns/10ps
module testbench;
    localparam int U = 10;
    logic               clk;
    logic               rst;
    logic               default_pins;
    logic               bus_wr;
    logic               bus_rd;
    logic [3:0]         src;
    rbs_pkg::rbs_addr_t bus_addr;
    rbs_pkg::rbs_word_t bus_wdata;
    rbs_pkg::rbs_word_t bus_rdata;
    rbs_pkg::rbs_word_t rd;
    rbs_pkg::rbs_mode_e boot_mode;
    logic [15:0]        pc_start;
    logic               sys_reset;
    logic               osc_pll_bypass;
    logic               user_jump;
    logic               ram_valid;
    logic               regulator_on;
    logic               power_down;
    logic               reset_pin_n;
    logic               tms;
    logic               boot_select_pin;
    logic               loader_frame;
    int                 fails;
    int                 n_checks;

    rbs_far_side u_rbs_far_side (.clk(clk), .reset_pin_n(reset_pin_n), .tms(tms),
        .boot_select_pin(boot_select_pin), .loader_frame(loader_frame));

    rbs_top #(.DELAY_UNIT_CYC(U)) u_rbs_top (.clk(clk), .rst(rst), .por_req(src[0]),
        .reset_pin_n(reset_pin_n), .malfunction_timer_expire(src[1]), .wake_req(src[2]),
        .brownout_req(src[3]), .tms(tms), .boot_select_pin(boot_select_pin),
        .default_pins(default_pins), .loader_frame(loader_frame), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .sys_reset(sys_reset), .boot_mode(boot_mode), .pc_start(pc_start),
        .osc_pll_bypass(osc_pll_bypass), .user_jump(user_jump), .ram_valid(ram_valid),
        .regulator_on(regulator_on), .power_down(power_down));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic finish_test();
        if (fails == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
            fails++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rdb(input logic [7:0] a);
        @(posedge clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1 rd = bus_rdata;
    endtask

    task automatic pulse(input logic [3:0] k);
        @(posedge clk);
        src <= k;
        @(posedge clk);
        src <= 4'h0;
    endtask

    task automatic wait_boot();
        int n;
        n = 0;
        #1;
        while (sys_reset !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1 n++;
        end
        check("reset entered", sys_reset, 1'b1);
        n = 0;
        while (sys_reset !== 1'b0 && n < 40) begin
            @(posedge clk);
            #1 n++;
        end
        if (n == 40) begin
            fails++;
            finish_test();
        end
    endtask

    task automatic quiet(input int cyc);
        repeat (cyc) begin
            @(posedge clk);
            #1 check("no reset", sys_reset, 1'b0);
        end
    endtask

    task automatic jump(input int limit, output int n);
        n = 0;
        while (user_jump !== 1'b1 && n < limit) begin
            @(posedge clk);
            #1 n++;
        end
    endtask

    task automatic t_power_on();
        wait_boot();
        check("mode", boot_mode, rbs_pkg::RBS_MODE_LOADER);
        check("pc", pc_start, rbs_pkg::PC_BOOT);
        check("bypass", osc_pll_bypass, 1'b0);
        check("ram", ram_valid, 1'b0);
        rdb(rbs_pkg::OFS_STATUS);
        check("cause", rd[6:2], 5'b00001);
        rdb(8'h3C);
        check("unmapped", rd, 32'h0);
    endtask

    task automatic t_boot_table();
        logic [3:0] tb_row[4] = '{4'b1011, 4'b1100, 4'b1111, 4'b0001};
        logic [1:0] mode_row[4] = '{2'b01, 2'b10, 2'b11, 2'b11};
        wr(rbs_pkg::OFS_NVPARAM, 32'h0);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) default_pins <= tb_row[i][3];
            u_rbs_far_side.set_straps(tb_row[i][2], tb_row[i][1]);
            u_rbs_far_side.pin_reset(2);
            wait_boot();
            check("boot mode", boot_mode, mode_row[i]);
            rdb(rbs_pkg::OFS_STATUS);
            check("boot opt", rd[10:9], tb_row[i][2:1]);
            check("cause", rd[6:2], 5'b00010);
        end
        @(posedge clk) default_pins <= 1'b1;
    endtask

    task automatic t_warm_latch();
        u_rbs_far_side.set_straps(1'b1, 1'b0);
        u_rbs_far_side.pin_reset(2);
        wait_boot();
        check("debug", boot_mode, rbs_pkg::RBS_MODE_DEBUG);
        wr(rbs_pkg::OFS_CTRL, 32'h1);
        u_rbs_far_side.set_straps(1'b0, 1'b1);
        pulse(4'b0010);
        wait_boot();
        check("latched", boot_mode, rbs_pkg::RBS_MODE_DEBUG);
        check("ram kept", ram_valid, 1'b1);
        rdb(rbs_pkg::OFS_STATUS);
        check("cause", rd[6:2], 5'b00100);
        u_rbs_far_side.pin_reset(1);
        quiet(4);
    endtask

    task automatic t_power_down();
        pulse(4'b0100);
        quiet(4);
        wr(rbs_pkg::OFS_CTRL, 32'h3);
        @(posedge clk);
        #1 check("pd", power_down, 1'b1);
        check("reg off", regulator_on, 1'b0);
        pulse(4'b0100);
        wait_boot();
        check("reg on", regulator_on, 1'b1);
        check("pd left", power_down, 1'b0);
        check("ram wake", ram_valid, 1'b1);
        rdb(rbs_pkg::OFS_STATUS);
        check("cause", rd[6:2], 5'b01000);
        wr(rbs_pkg::OFS_CTRL, 32'h2);
        u_rbs_far_side.pin_reset(2);
        wait_boot();
        check("pin in pd", power_down, 1'b0);
        check("cold mode", boot_mode, rbs_pkg::RBS_MODE_LOADER);
        pulse(4'b1000);
        wait_boot();
        check("ram brown", ram_valid, 1'b0);
        rdb(rbs_pkg::OFS_STATUS);
        check("cause", rd[6:2], 5'b10000);
    endtask

    // Power-on request mid-run: RAM lost, straps taken afresh
    task automatic t_por();
        wr(rbs_pkg::OFS_CTRL, 32'h1);
        u_rbs_far_side.set_straps(1'b1, 1'b0);
        pulse(4'b0001);
        wait_boot();
        check("ram por", ram_valid, 1'b0);
        check("por mode", boot_mode, rbs_pkg::RBS_MODE_DEBUG);
        rdb(rbs_pkg::OFS_STATUS);
        check("cause", rd[6:2], 5'b00001);
        check("por opt", rd[10:9], 2'b10);
    endtask

    task automatic t_idle_valid();
        logic [7:0] v[3] = '{8'h01, 8'h02, 8'h0C};
        int n;
        u_rbs_far_side.set_straps(1'b0, 1'b0);
        for (int i = 0; i < 3; i++) begin
            wr(rbs_pkg::OFS_NVPARAM, {8'h01, 8'h00, ~v[i], v[i]});
            rdb(rbs_pkg::OFS_NVPARAM);
            check("nv", rd, {8'h01, 8'h00, ~v[i], v[i]});
            u_rbs_far_side.pin_reset(2);
            wait_boot();
            jump(200, n);
            check("delay", n, (v[i] - 1) * U);
            check("user", boot_mode, rbs_pkg::RBS_MODE_USER);
        end
    endtask

    task automatic t_idle_invalid();
        logic [31:0] w[5] = '{32'h0100F20D, 32'h0100FF00, 32'h0100FD03,
                              32'h0101FC03, 32'h0000FC03};
        int n;
        for (int i = 0; i < 5; i++) begin
            wr(rbs_pkg::OFS_NVPARAM, w[i]);
            u_rbs_far_side.pin_reset(2);
            wait_boot();
            jump(13 * U, n);
            check("no jump", n, 13 * U);
            check("loader", boot_mode, rbs_pkg::RBS_MODE_LOADER);
        end
    endtask

    task automatic t_frame();
        int n;
        wr(rbs_pkg::OFS_NVPARAM, 32'h0100FB04);
        u_rbs_far_side.pin_reset(2);
        wait_boot();
        repeat (5) @(posedge clk);
        u_rbs_far_side.send_frame();
        jump(40, n);
        check("frame stops jump", n, 40);
        check("loader", boot_mode, rbs_pkg::RBS_MODE_LOADER);
    endtask

    initial begin
        rst = 1'b1;
        src = 4'h0;
        default_pins = 1'b1;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_addr = 8'h00;
        bus_wdata = 32'h0;
        fails = 0;
        n_checks = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_power_on();
        t_boot_table();
        t_warm_latch();
        t_power_down();
        t_por();
        t_idle_valid();
        t_idle_invalid();
        t_frame();
        finish_test();
    end
endmodule
